// File: common/fnc_defines.svh
// Constants of the fieldbus node configuration and status block.
// Assumes inclusion by bare name from the package, whose macros the design file then uses.
`ifndef FNC_DEFINES_SVH
`define FNC_DEFINES_SVH

// ************************************************************
// Register byte offsets on the APB
// ************************************************************
`define FNC_OFF_NET_ADDR 12'h000
`define FNC_OFF_NET_SPEED 12'h004
`define FNC_OFF_FAIL_SRC 12'h008
`define FNC_OFF_FAULT_ACT 12'h00c
`define FNC_OFF_FAULT_VAL 12'h010
`define FNC_OFF_POINT_ACT 12'h014
`define FNC_OFF_POINT_VAL 12'h018
`define FNC_OFF_STATUS 12'h01c

// ************************************************************
// Reset values, limits and field positions
// ************************************************************
`define FNC_ADDR_RESET 6'h3f
`define FNC_SPEED_RESET 2'h0
`define FNC_SPEED_MAX 2'h2
`define FNC_SPEED_BAD 2'h3
`define FNC_ADDR_MAX 32'h0000003f
`define FNC_SWITCH_RESET 10'h3f0
`define FNC_SW_MODE 0
`define FNC_SW_HOLD 1
`define FNC_SW_SPEED_HI 2
`define FNC_SW_SPEED_LO 3
`define FNC_SW_ADDR_LO 4
`define FNC_PT_IDX_HI 4
`define FNC_PT_VAL_BIT 8
`define FNC_ST_SPEED_LO 8
`define FNC_ST_PARAM_ERR 16
`define FNC_ST_SWITCH_BAD 17
`define FNC_ST_SUPPLY_FAULT 24
`define FNC_ST_NET_MODE 25
`define FNC_DIAG_SUPPLY_BIT 2
`define FNC_DIAG_OTHER_MASK 8'hfb

// ************************************************************
// Timing
// ************************************************************
`define FNC_CLK_KHZ 250000
`define FNC_FLASH_HALF_MS 500

`endif

// File: common/fnc_pkg.sv
// Types shared by the node configuration and status block.
// Assumes the defines header sits beside it on the include path.
package fnc_pkg;

    `include "fnc_defines.svh"

    // ************************************************************
    // Lamp indications
    // ************************************************************
    typedef enum logic [2:0] {
        LAMP_OFF,
        LAMP_GREEN,
        LAMP_RED,
        LAMP_GREEN_FLASH,
        LAMP_RED_FLASH
    } fnc_lamp_type;

endpackage : fnc_pkg

// File: logic/fnc_node_config.sv
// Node configuration, fail-safe output and status lamp logic of a fieldbus valve node.
// Assumes a protocol engine supplies link state and output data synchronous to SYS_CLK,
// and that software reaches the settings over a zero-wait APB slave port.
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps

module fnc_node_config
    import fnc_pkg::*;
#(
    parameter int FLASH_HALF = `FNC_FLASH_HALF_MS * `FNC_CLK_KHZ,
    parameter int POINTS = 32
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [9:0] CFG_SWITCH,
    input wire logic NET_POWER,
    input wire logic VALVE_SUPPLY_OK,
    input wire logic DUP_CHECK_DONE,
    input wire logic ONLINE,
    input wire logic CONN_ESTABLISHED,
    input wire logic WDT_ERROR,
    input wire logic BUS_OFF,
    input wire logic DUP_ADDR,
    input wire logic IO_TIMEOUT,
    input wire logic COMM_FAULT,
    input wire logic [POINTS-1:0] OUT_DATA,
    output logic [POINTS-1:0] OUTPUT_POINTS,
    output logic [5:0] NODE_ADDR,
    output logic [1:0] LINK_SPEED,
    output logic [7:0] DIAG_BYTE,
    output logic NET_LAMP_GREEN,
    output logic NET_LAMP_RED,
    output logic MOD_LAMP_GREEN,
    output logic MOD_LAMP_RED,
    output logic NET_POWER_LAMP,
    output logic VALVE_POWER_LAMP
);

    localparam int FW = $clog2(FLASH_HALF + 1);
    localparam logic [FW-1:0] FLASH_LAST = FW'(FLASH_HALF - 1);

    // ************************************************************
    // Reset release
    // ************************************************************
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ************************************************************
    // Switch sampling and decode
    // ************************************************************
    logic net_pwr_q;
    logic net_rise;
    logic [9:0] sw_q;
    logic [5:0] sw_addr;
    logic [1:0] sw_speed;
    logic net_mode;
    logic switch_bad;

    assign net_rise = NET_POWER & ~net_pwr_q;

    // Switches change only with power off, so one capture per power-up is enough.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            net_pwr_q <= 1'b0;
            sw_q <= `FNC_SWITCH_RESET;
        end else begin
            net_pwr_q <= NET_POWER;
            if (net_rise) begin
                sw_q <= CFG_SWITCH;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_addr
            assign sw_addr[5-gi] = sw_q[`FNC_SW_ADDR_LO + gi];
        end
    endgenerate

    assign sw_speed = {sw_q[`FNC_SW_SPEED_HI], sw_q[`FNC_SW_SPEED_LO]};
    assign net_mode = sw_q[`FNC_SW_MODE];
    assign switch_bad = ~net_mode & (sw_speed == `FNC_SPEED_BAD);

    // ************************************************************
    // APB slave
    // ************************************************************
    logic wr_en;
    logic rd_setup;
    logic [31:0] rd_mux;
    logic rd_err;
    logic wr_err;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [5:0] nv_addr_q;
    logic [1:0] nv_speed_q;
    logic fail_src_q;
    logic [POINTS-1:0] fault_act_q;
    logic [POINTS-1:0] fault_val_q;
    logic param_err_q;
    logic bad_value;
    logic good_value;
    logic supply_fault;
    logic [31:0] status_word;

    assign wr_en = PSEL & PENABLE & PWRITE;
    assign rd_setup = PSEL & ~PENABLE;
    assign supply_fault = ~VALVE_SUPPLY_OK;

    always_comb begin
        status_word = 32'h0;
        status_word[5:0] = NODE_ADDR;
        status_word[`FNC_ST_SPEED_LO +: 2] = LINK_SPEED;
        status_word[`FNC_ST_PARAM_ERR] = param_err_q;
        status_word[`FNC_ST_SWITCH_BAD] = switch_bad;
        status_word[`FNC_ST_SUPPLY_FAULT] = supply_fault;
        status_word[`FNC_ST_NET_MODE] = net_mode;
    end

    always_comb begin
        rd_mux = 32'h0;
        rd_err = 1'b0;
        wr_err = 1'b0;
        unique case (PADDR)
            `FNC_OFF_NET_ADDR: begin
                rd_mux[5:0] = nv_addr_q;
                wr_err = ~net_mode | (PWDATA > `FNC_ADDR_MAX);
            end
            `FNC_OFF_NET_SPEED: begin
                rd_mux[1:0] = nv_speed_q;
                wr_err = ~net_mode | (PWDATA > {30'h0, `FNC_SPEED_MAX});
            end
            `FNC_OFF_FAIL_SRC: rd_mux[0] = fail_src_q;
            `FNC_OFF_FAULT_ACT: rd_mux[POINTS-1:0] = fault_act_q;
            `FNC_OFF_FAULT_VAL: rd_mux[POINTS-1:0] = fault_val_q;
            `FNC_OFF_POINT_ACT, `FNC_OFF_POINT_VAL: begin
                rd_mux = 32'h0;
            end
            `FNC_OFF_STATUS: begin
                rd_mux = status_word;
                wr_err = 1'b1;
            end
            default: begin
                rd_err = 1'b1;
                wr_err = 1'b1;
            end
        endcase
    end

    // An out-of-range address or speed in network mode is a failed parameter write.
    assign bad_value = wr_en & net_mode & wr_err & ~rd_err &
        ((PADDR == `FNC_OFF_NET_ADDR) | (PADDR == `FNC_OFF_NET_SPEED));
    assign good_value = wr_en & ~wr_err &
        ((PADDR == `FNC_OFF_NET_ADDR) | (PADDR == `FNC_OFF_NET_SPEED));

    // Read data and error are captured in the setup cycle, so the slave never waits.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end else if (rd_setup) begin
            prdata_q <= PWRITE ? 32'h0 : rd_mux;
            pslverr_q <= PWRITE ? wr_err : rd_err;
        end
    end

    assign PRDATA = prdata_q;
    assign PSLVERR = pslverr_q;
    assign PREADY = 1'b1;

    // Cleared by the power-on reset and by a power-up in local mode, so network power loss in network mode keeps them.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            nv_addr_q <= `FNC_ADDR_RESET;
            nv_speed_q <= `FNC_SPEED_RESET;
        end else if (net_rise && !CFG_SWITCH[`FNC_SW_MODE]) begin
            nv_addr_q <= `FNC_ADDR_RESET;
            nv_speed_q <= `FNC_SPEED_RESET;
        end else if (wr_en && !wr_err && PADDR == `FNC_OFF_NET_ADDR) begin
            nv_addr_q <= PWDATA[5:0];
        end else if (wr_en && !wr_err && PADDR == `FNC_OFF_NET_SPEED) begin
            nv_speed_q <= PWDATA[1:0];
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            param_err_q <= 1'b0;
        end else if (bad_value) begin
            param_err_q <= 1'b1;
        end else if (good_value) begin
            param_err_q <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            fail_src_q <= 1'b0;
            fault_act_q <= '0;
            fault_val_q <= '0;
        end else if (wr_en) begin
            unique case (PADDR)
                `FNC_OFF_FAIL_SRC: fail_src_q <= PWDATA[0];
                `FNC_OFF_FAULT_ACT: fault_act_q <= PWDATA[POINTS-1:0];
                `FNC_OFF_FAULT_VAL: fault_val_q <= PWDATA[POINTS-1:0];
                `FNC_OFF_POINT_ACT: begin
                    fault_act_q[PWDATA[`FNC_PT_IDX_HI:0]] <= PWDATA[`FNC_PT_VAL_BIT];
                end
                `FNC_OFF_POINT_VAL: begin
                    fault_val_q[PWDATA[`FNC_PT_IDX_HI:0]] <= PWDATA[`FNC_PT_VAL_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // Effective settings and fail-safe outputs
    // ************************************************************
    logic [POINTS-1:0] last_q;
    logic [POINTS-1:0] fault_vec;
    logic [POINTS-1:0] out_q;

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            NODE_ADDR <= `FNC_ADDR_RESET;
            LINK_SPEED <= `FNC_SPEED_RESET;
        end else begin
            NODE_ADDR <= net_mode ? nv_addr_q : sw_addr;
            LINK_SPEED <= net_mode ? nv_speed_q : sw_speed;
        end
    end

    generate
        for (gi = 0; gi < POINTS; gi++) begin : g_fault
            logic hold_b;
            logic val_b;
            assign hold_b = fail_src_q ? fault_act_q[gi] : sw_q[`FNC_SW_HOLD];
            assign val_b = fail_src_q & fault_val_q[gi];
            assign fault_vec[gi] = hold_b ? last_q[gi] : val_b;
        end
    endgenerate

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            last_q <= '0;
            out_q <= '0;
        end else begin
            if (!COMM_FAULT) begin
                last_q <= OUT_DATA;
            end
            out_q <= COMM_FAULT ? fault_vec : OUT_DATA;
        end
    end
    assign OUTPUT_POINTS = out_q;

    // ************************************************************
    // Lamps
    // ************************************************************
    logic [FW-1:0] flash_cnt_q;
    logic phase_q;
    fnc_lamp_type net_lamp_mode;
    fnc_lamp_type mod_lamp_mode;

    // One shared rate with even halves keeps both lamps flashing in step.
    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            flash_cnt_q <= '0;
            phase_q <= 1'b0;
        end else if (flash_cnt_q == FLASH_LAST) begin
            flash_cnt_q <= '0;
            phase_q <= ~phase_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + 1'b1;
        end
    end

    always_comb begin
        net_lamp_mode = LAMP_OFF;
        mod_lamp_mode = LAMP_GREEN;
        if (!NET_POWER) begin
            mod_lamp_mode = LAMP_OFF;
        end else if (WDT_ERROR) begin
            mod_lamp_mode = LAMP_RED;
        end else if (switch_bad || param_err_q) begin
            mod_lamp_mode = LAMP_RED_FLASH;
        end else if (BUS_OFF || DUP_ADDR) begin
            net_lamp_mode = LAMP_RED;
        end else if (IO_TIMEOUT) begin
            net_lamp_mode = LAMP_RED_FLASH;
        end else if (!DUP_CHECK_DONE) begin
            net_lamp_mode = LAMP_OFF;
        end else if (ONLINE && CONN_ESTABLISHED) begin
            net_lamp_mode = LAMP_GREEN;
        end else if (ONLINE) begin
            net_lamp_mode = LAMP_GREEN_FLASH;
        end
    end

    function automatic logic [1:0] lamp_drive(fnc_lamp_type m, logic ph);
        logic [1:0] gr;
        gr = 2'h0;
        unique case (m)
            LAMP_OFF: gr = 2'h0;
            LAMP_GREEN: gr = 2'h2;
            LAMP_RED: gr = 2'h1;
            LAMP_GREEN_FLASH: gr = {ph, 1'b0};
            LAMP_RED_FLASH: gr = {1'b0, ph};
            default: gr = 2'h0;
        endcase
        return gr;
    endfunction : lamp_drive

    always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            {NET_LAMP_GREEN, NET_LAMP_RED} <= 2'h0;
            {MOD_LAMP_GREEN, MOD_LAMP_RED} <= 2'h0;
            NET_POWER_LAMP <= 1'b0;
            VALVE_POWER_LAMP <= 1'b0;
            DIAG_BYTE <= 8'h0;
        end else begin
            {NET_LAMP_GREEN, NET_LAMP_RED} <= lamp_drive(net_lamp_mode, phase_q);
            {MOD_LAMP_GREEN, MOD_LAMP_RED} <= lamp_drive(mod_lamp_mode, phase_q);
            NET_POWER_LAMP <= NET_POWER;
            VALVE_POWER_LAMP <= VALVE_SUPPLY_OK;
            DIAG_BYTE <= 8'h0;
            DIAG_BYTE[`FNC_DIAG_SUPPLY_BIT] <= supply_fault;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    supply_flag_pair_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        1'b1 |=> VALVE_POWER_LAMP == $past(VALVE_SUPPLY_OK) &&
        DIAG_BYTE[`FNC_DIAG_SUPPLY_BIT] != $past(VALVE_SUPPLY_OK))
        else $error("Valve lamp and supply flag disagree.");
    net_power_lamp_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        $rose(NET_POWER) |=> NET_POWER_LAMP)
        else $error("Network power lamp missed power-up.");
    dark_lamps_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        !NET_POWER |=> !NET_LAMP_GREEN && !NET_LAMP_RED && !MOD_LAMP_GREEN && !MOD_LAMP_RED)
        else $error("State lamps lit without network power.");
    watchdog_red_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        NET_POWER && WDT_ERROR |=> MOD_LAMP_RED && !MOD_LAMP_GREEN && !NET_LAMP_GREEN &&
        !NET_LAMP_RED)
        else $error("Watchdog error not shown.");
    bus_off_red_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        NET_POWER && !WDT_ERROR && !switch_bad && !param_err_q && (BUS_OFF || DUP_ADDR)
        |=> NET_LAMP_RED && !NET_LAMP_GREEN && MOD_LAMP_GREEN)
        else $error("Bus-off indication wrong.");
    online_green_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        net_lamp_mode == LAMP_GREEN ##1 net_lamp_mode == LAMP_GREEN |->
        NET_LAMP_GREEN && MOD_LAMP_GREEN)
        else $error("Connected node not steady green.");
    bad_write_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        bad_value && NET_POWER && !WDT_ERROR ##1 NET_POWER && !WDT_ERROR |->
        param_err_q ##1 (MOD_LAMP_RED == phase_q || $past(phase_q) != phase_q))
        else $error("Failed parameter write not flagged.");
    diag_zero_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        (DIAG_BYTE & `FNC_DIAG_OTHER_MASK) == 8'h0)
        else $error("Diagnostic byte has stray bits.");
    local_addr_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        !net_mode && !net_rise |=> NODE_ADDR == {sw_q[4], sw_q[5], sw_q[6], sw_q[7],
        sw_q[8], sw_q[9]})
        else $error("Local address decode wrong.");
    clear_outputs_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        COMM_FAULT && !fail_src_q && !sw_q[`FNC_SW_HOLD] |=> OUTPUT_POINTS == '0)
        else $error("Outputs not cleared on fault.");
    flash_toggle_a: assert property (@(posedge SYS_CLK) disable iff (!rst_n)
        flash_cnt_q == FLASH_LAST |=> phase_q != $past(phase_q) && flash_cnt_q == '0)
        else $error("Flash phase did not toggle.");

endmodule : fnc_node_config

// File: verification/fnc_master_model.sv
// Link-state model of the network master and protocol engine side.
// Assumes the bench picks one link condition at a time, just after an edge.
`timescale 1ns/1ps
module fnc_master_model (
    input wire logic [2:0] cond,
    input wire logic fault_in,
    output logic dup_done,
    output logic online,
    output logic conn,
    output logic wdt,
    output logic bus_off,
    output logic dup_addr,
    output logic io_timeout,
    output logic comm_fault
);
    // ************************************************************
    // Link condition decode
    // ************************************************************
    // Levels follow cond at once, so the node sees each state from the next edge.
    assign dup_done = cond != 3'h0;
    assign online = cond == 3'h1 || cond == 3'h2 || cond == 3'h6;
    assign conn = cond == 3'h1;
    assign wdt = cond == 3'h3;
    assign bus_off = cond == 3'h4;
    assign dup_addr = cond == 3'h5;
    assign io_timeout = cond == 3'h6;
    assign comm_fault = fault_in;
endmodule : fnc_master_model

// File: verification/fnc_node_config_test.sv
// Self-checking bench of the node configuration and status block.
// Assumes the link-state model beside it and a zero-wait APB slave.
`timescale 1ns/1ps
module fnc_node_config_test;
    import fnc_pkg::*;
    localparam int HALF = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [9:0] sw = `FNC_SWITCH_RESET;
    logic bus_power = 1'b0, vok = 1'b1, fault = 1'b0;
    logic [2:0] cond = 3'h0;
    logic [31:0] od = 32'h0;
    logic [31:0] prdata, rd, op;
    logic [5:0] na;
    logic [1:0] ls;
    logic [7:0] diag;
    logic pready, pslverr, err, nsg, nsr, msg, msr, npl, vpl;
    logic dd, onl, cn, wd, bo, da, iot, cf;
    int miscompares = 0;
    int checks_done = 0;
    fnc_lamp_type net_exp [7] = '{LAMP_OFF, LAMP_GREEN, LAMP_GREEN_FLASH, LAMP_OFF,
        LAMP_RED, LAMP_RED, LAMP_RED_FLASH};
    fnc_lamp_type mod_exp [7] = '{LAMP_GREEN, LAMP_GREEN, LAMP_GREEN, LAMP_RED,
        LAMP_GREEN, LAMP_GREEN, LAMP_GREEN};
    fnc_master_model i_master (.cond(cond), .fault_in(fault), .dup_done(dd),
        .online(onl), .conn(cn), .wdt(wd), .bus_off(bo), .dup_addr(da),
        .io_timeout(iot), .comm_fault(cf));
    fnc_node_config #(.FLASH_HALF(HALF), .POINTS(32)) i_dut (
        .SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CFG_SWITCH(sw), .NET_POWER(bus_power), .VALVE_SUPPLY_OK(vok),
        .DUP_CHECK_DONE(dd), .ONLINE(onl), .CONN_ESTABLISHED(cn), .WDT_ERROR(wd),
        .BUS_OFF(bo), .DUP_ADDR(da), .IO_TIMEOUT(iot), .COMM_FAULT(cf), .OUT_DATA(od),
        .OUTPUT_POINTS(op), .NODE_ADDR(na), .LINK_SPEED(ls), .DIAG_BYTE(diag),
        .NET_LAMP_GREEN(nsg), .NET_LAMP_RED(nsr), .MOD_LAMP_GREEN(msg), .MOD_LAMP_RED(msr),
        .NET_POWER_LAMP(npl), .VALVE_POWER_LAMP(vpl));
    initial begin
        forever #2 clk = ~clk;
    end
    // ************************************************************
    // Bus cycles and comparisons
    // ************************************************************
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask : step
    task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", w, exp, seen);
        end
    endtask : check
    // The request is held from setup until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        step(2);
    endtask : apb
    task automatic power(input logic on);
        bus_power <= on;
        step(5);
    endtask : power
    // Switch n sits at bit n-1, and switch 5 carries the address MSB.
    function automatic logic [9:0] swv(logic md, logic hd, logic [1:0] sp, logic [5:0] ad);
        return {ad[0], ad[1], ad[2], ad[3], ad[4], ad[5], sp[0], sp[1], hd, md};
    endfunction : swv
    function automatic int lit(fnc_lamp_type e, logic red);
        if (e == (red ? LAMP_RED : LAMP_GREEN)) return 2 * HALF;
        return e == (red ? LAMP_RED_FLASH : LAMP_GREEN_FLASH) ? HALF : 0;
    endfunction : lit
    // Over one whole flash period a steady lamp is lit every cycle, a flashing one exactly half, an off one never.
    task automatic lamps(input fnc_lamp_type ne, input fnc_lamp_type me);
        int c [4] = '{0, 0, 0, 0};
        step(3);
        repeat (2 * HALF) begin
            @(posedge clk);
            c[0] += int'(nsg === 1'b1);
            c[1] += int'(nsr === 1'b1);
            c[2] += int'(msg === 1'b1);
            c[3] += int'(msr === 1'b1);
        end
        for (int i = 0; i < 4; i++) begin
            check("lamp", c[i], lit(i < 2 ? ne : me, i[0]));
        end
    endtask : lamps
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        step(12);
        rst_n <= 1'b1;
        cond <= 3'h1;
        step(4);
        check("addr", na, 32'h3f);
        check("speed", ls, 32'h0);
        check("pwr lamp", npl, 32'h0);
        lamps(LAMP_OFF, LAMP_OFF);
        sw <= swv(1'b0, 1'b0, 2'h1, 6'h25);
        power(1'b1);
        check("addr", na, 32'h25);
        check("speed", ls, 32'h1);
        check("pwr lamp", npl, 32'h1);
        sw <= swv(1'b0, 1'b0, 2'h2, 6'h0a);
        step(3);
        check("addr held", na, 32'h25);
        for (int i = 0; i < 7; i++) begin
            cond <= i[2:0];
            lamps(net_exp[i], mod_exp[i]);
        end
        cond <= 3'h1;
        for (int s = 0; s < 4; s++) begin
            power(1'b0);
            sw <= swv(1'b0, 1'b0, s[1:0], 6'h05);
            power(1'b1);
            check("speed", ls, s);
        end
        lamps(LAMP_OFF, LAMP_RED_FLASH);
        apb(1'b1, `FNC_OFF_NET_ADDR, 32'h9);
        check("local wr", err, 32'h1);
        check("addr", na, 32'h5);
        power(1'b0);
        sw <= swv(1'b1, 1'b0, 2'h3, 6'h00);
        power(1'b1);
        check("net addr", na, 32'h3f);
        apb(1'b1, `FNC_OFF_NET_ADDR, 32'h16);
        apb(1'b1, `FNC_OFF_NET_SPEED, 32'h2);
        apb(1'b0, `FNC_OFF_STATUS, 32'h0);
        check("status", rd, 32'h0200_0216);
        apb(1'b1, `FNC_OFF_NET_ADDR, 32'h40);
        check("range", err, 32'h1);
        lamps(LAMP_OFF, LAMP_RED_FLASH);
        apb(1'b1, `FNC_OFF_NET_ADDR, 32'h15);
        power(1'b0);
        power(1'b1);
        check("kept addr", na, 32'h15);
        check("kept speed", ls, 32'h2);
        power(1'b0);
        sw <= swv(1'b0, 1'b0, 2'h0, 6'h0c);
        power(1'b1);
        check("local addr", na, 32'h0c);
        power(1'b0);
        sw <= swv(1'b1, 1'b1, 2'h0, 6'h00);
        power(1'b1);
        check("discarded", na, 32'h3f);
        od <= 32'h1234_5678;
        step(3);
        check("out", op, 32'h1234_5678);
        fault <= 1'b1;
        od <= 32'h0;
        step(3);
        check("hold", op, 32'h1234_5678);
        apb(1'b1, `FNC_OFF_FAIL_SRC, 32'h1);
        apb(1'b1, `FNC_OFF_FAULT_ACT, 32'h0000_ffff);
        apb(1'b1, `FNC_OFF_FAULT_VAL, 32'h00ff_00ff);
        check("batch", op, 32'h00ff_5678);
        apb(1'b1, `FNC_OFF_POINT_ACT, 32'h0000_0110);
        apb(1'b1, `FNC_OFF_POINT_VAL, 32'h0000_011f);
        check("point", op, 32'h80fe_5678);
        apb(1'b1, `FNC_OFF_FAIL_SRC, 32'h0);
        check("sw src", op, 32'h1234_5678);
        power(1'b0);
        sw <= swv(1'b1, 1'b0, 2'h0, 6'h00);
        power(1'b1);
        check("clear", op, 32'h0);
        fault <= 1'b0;
        od <= 32'h8000_0001;
        vok <= 1'b0;
        step(3);
        check("out", op, 32'h8000_0001);
        check("diag", diag, 32'h04);
        check("valve lamp", vpl, 32'h0);
        apb(1'b0, `FNC_OFF_STATUS, 32'h0);
        check("supply", rd[24], 32'h1);
        vok <= 1'b1;
        step(3);
        check("diag", diag, 32'h0);
        check("valve lamp", vpl, 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        check("unmapped", err, 32'h1);
        complete_run();
    end
    initial begin
        step(20000);
        miscompares++;
        complete_run();
    end
endmodule : fnc_node_config_test
